// ### src/mph_ctrl.sv
/*
  Mode 0 port handshake controller, two independent 8-bit ports.
  Holds control, general, status, data and direction registers behind
  an AXI4-Lite slave, the double-buffered output path, the second
  handshake pin logic and the request gating.
  Assumes pin inputs are asynchronous and are synchronised here.
*/
// Operation
// - Bits 7:6 select submode; 00 is input
// - Control 0XX: aux pin edge input, sets status
// - 100 negated, 101 asserted, status clear
// - 110 interlocked, 111 pulsed, status clear
// - Bit 2 gates aux status interrupt
// - Bit 1 gates service request from latch status
// - Input submode: status shows unread input data
// - Port B uses identical field layout
// - Submode 01: double-buffered output, strobe accepts
// - Status select 0: either latch accepts data
// - Status select 1: both latches empty
// - Aux status set on edge, cleared three ways
// - Handshake asserts two cycles after transfer
// - Hold data until strobe, then negate, advance
// - Strobe ignored while handshake output negated
// - Handshake negated while transfer enable clear
// - Pulsed handshake lasts at most four cycles
// - Input-direction pins latch data, buffers off
// - Bit 0 selects output status interpretation
`timescale 1ns/1ps
`default_nettype none
module mph_ctrl
  import mph_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire mph_pin_in_t  pin_a_in,
  input  wire mph_pin_in_t  pin_b_in,
  input  wire logic [7:0]   port_a_data_in,
  input  wire logic [7:0]   port_b_data_in,
  output mph_pin_out_t      pin_a_out,
  output mph_pin_out_t      pin_b_out,
  output mph_req_t          req_a,
  output mph_req_t          req_b
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  ddr;
    logic [7:0]  il;        // initial latch (output) or second input
    logic [7:0]  fl;        // final latch
    logic        il_full;
    logic        fl_full;
    logic        aux_st;
    logic        hs;        // handshake output level
    logic [2:0]  cnt;       // assert delay / pulse length count
    logic        pend;      // delay running toward assertion
    logic [1:0]  sync_s;    // strobe sync
    logic [1:0]  sync_a;    // aux pin sync
    logic        s_prev;
    logic        a_prev;
    logic [7:0]  din_s;     // input data sync, first stage
    logic [7:0]  din_q;     // input data sync, second stage
  } mph_port_t;

  typedef struct packed {
    mph_port_t   pa;
    mph_port_t   pb;
    logic [7:0]  gen;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic        rerr;
    logic        berr;
  } mph_state_t;

  mph_state_t st_q;
  mph_state_t st_d;

  // Latch status per submode and interpretation
  function automatic logic lat_status(input mph_port_t p);
    if (p.ctrl[MPH_SUB_HI:MPH_SUB_LO] == MPH_SUB_OUT) begin
      if (p.ctrl[MPH_STAT_SEL])
        return !p.il_full && !p.fl_full;
      return !(p.il_full && p.fl_full);
    end
    return p.il_full || p.fl_full;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= MPH_OFF_DDR_B;
  endfunction

  // Per-port next-state step; wr/rd flags are bus actions on this port
  function automatic mph_port_t port_step(
    input mph_port_t   p,
    input mph_pin_in_t pin,
    input logic [7:0]  din,
    input logic        en,
    input logic        wr_data,
    input logic [7:0]  wval,
    input logic        rd_data,
    input logic        clr_aux
  );
    mph_port_t n;
    logic      s_edge;
    logic      a_edge;
    logic      hs_mode;
    logic [2:0] hc;
    n       = p;
    n.sync_s = {p.sync_s[0], pin.strobe_in};
    n.sync_a = {p.sync_a[0], pin.aux_in};
    n.s_prev = p.sync_s[1];
    n.a_prev = p.sync_a[1];
    n.din_s  = din;
    n.din_q  = p.din_s;
    // Asserted edge taken as a rising edge of the synchronised pin
    s_edge  = p.sync_s[1] && !p.s_prev;
    a_edge  = p.sync_a[1] && !p.a_prev;
    hc      = p.ctrl[MPH_HS_HI:MPH_HS_LO];
    hs_mode = hc == MPH_HS_ILOCK || hc == MPH_HS_PULSE;
    if (p.ctrl[MPH_SUB_HI:MPH_SUB_LO] == MPH_SUB_OUT) begin
      // Handshake ends on strobe; strobes while negated do nothing
      if (s_edge && p.hs && en) begin
        n.hs      = 1'b0;
        n.fl_full = 1'b0;
      end
      if (hs_mode && p.hs && hc == MPH_HS_PULSE) begin
        n.cnt = p.cnt + 3'h1;
        if (p.cnt == 3'(MPH_PULSE_CYC - 1))
          n.hs = 1'b0;
      end
      // Written data enters the initial latch (also for input pins)
      if (wr_data) begin
        n.il      = wval;
        n.il_full = 1'b1;
      end
      // Advance the queue once the final latch is free
      if (!n.fl_full && p.il_full) begin
        n.fl      = p.il;
        n.fl_full = 1'b1;
        n.il_full = wr_data;
        n.pend    = hs_mode && en;
        n.cnt     = 3'h0;
      end else if (p.pend) begin
        n.cnt = p.cnt + 3'h1;
        if (p.cnt == 3'(MPH_ASSERT_DLY_CYC - 1)) begin
          n.pend = 1'b0;
          n.hs   = 1'b1;
          n.cnt  = 3'h0;
        end
      end
    end else if (p.ctrl[MPH_SUB_HI:MPH_SUB_LO] == MPH_SUB_IN) begin
      // Double-buffered input: strobe captures into the free latch
      if (s_edge && en && !(p.il_full && p.fl_full)) begin
        if (!p.fl_full) begin
          n.fl      = p.din_q;
          n.fl_full = 1'b1;
        end else begin
          n.il      = p.din_q;
          n.il_full = 1'b1;
        end
      end
      // A read that meets a capture moves the new word up, not a stale one
      if (rd_data && p.fl_full) begin
        n.fl      = n.il;
        n.fl_full = n.il_full;
        n.il_full = 1'b0;
      end
      n.hs   = 1'b0;
      n.pend = 1'b0;
    end
    // Aux status: set wins over clear
    if (hc[2]) begin
      n.aux_st = 1'b0;
    end else begin
      if (clr_aux)
        n.aux_st = 1'b0;
      if (a_edge && en)
        n.aux_st = 1'b1;
      if (!en)
        n.aux_st = 1'b0;
    end
    if (!hs_mode || !en) begin
      n.hs   = 1'b0;
      n.pend = 1'b0;
    end
    return n;
  endfunction

  // Output drive for the aux pin; enable low while driving
  function automatic mph_pin_out_t pin_drive(input mph_port_t p, input logic en);
    mph_pin_out_t o;
    logic [2:0]   hc;
    hc          = p.ctrl[MPH_HS_HI:MPH_HS_LO];
    o.data_out  = p.fl;
    o.data_oe_n = ~p.ddr;
    o.aux_oe_n  = !hc[2];
    o.aux_out   = (hc == MPH_HS_ASRT) ? 1'b1 :
                  (hc == MPH_HS_NEG)  ? 1'b0 : p.hs && en;
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        do_wr;
  logic        do_rd;
  logic [7:0]  wa;
  logic [7:0]  wb;
  logic [31:0] rd;

  always_comb begin
    st_d  = st_q;
    // Take address and data in either order, answer after both
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_hold = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_hold = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    do_wr = st_q.aw_hold && st_q.w_hold && !st_q.bvalid;
    do_rd = s_axi_arvalid && s_axi_arready;
    wa    = st_q.aw_addr;
    wb    = st_q.w_data[7:0];
    if (do_wr) begin
      st_d.aw_hold = 1'b0;
      st_d.w_hold  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.berr    = !addr_known(wa);
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    // Port updates; both ports share one layout
    st_d.pa = port_step(st_q.pa, pin_a_in, port_a_data_in,
      st_q.gen[MPH_GEN_EN_A],
      do_wr && st_q.w_strb[0] && wa == MPH_OFF_DATA_A, wb,
      do_rd && s_axi_araddr == MPH_OFF_DATA_A,
      do_wr && st_q.w_strb[0] && wa == MPH_OFF_STATUS && wb[MPH_ST_AUX_A]);
    st_d.pb = port_step(st_q.pb, pin_b_in, port_b_data_in,
      st_q.gen[MPH_GEN_EN_B],
      do_wr && st_q.w_strb[0] && wa == MPH_OFF_DATA_B, wb,
      do_rd && s_axi_araddr == MPH_OFF_DATA_B,
      do_wr && st_q.w_strb[0] && wa == MPH_OFF_STATUS && wb[MPH_ST_AUX_B]);
    // Register writes; submode changes are trusted to software
    if (do_wr && st_q.w_strb[0]) begin
      unique case (wa)
        MPH_OFF_A_CTRL: st_d.pa.ctrl = wb;
        MPH_OFF_B_CTRL: st_d.pb.ctrl = wb;
        MPH_OFF_GEN:    st_d.gen     = wb;
        MPH_OFF_DDR_A:  st_d.pa.ddr  = wb;
        MPH_OFF_DDR_B:  st_d.pb.ddr  = wb;
        default: ;
      endcase
    end
    // Read mux
    rd = 32'h0;
    unique case (s_axi_araddr)
      MPH_OFF_A_CTRL: rd[7:0] = st_q.pa.ctrl;
      MPH_OFF_B_CTRL: rd[7:0] = st_q.pb.ctrl;
      MPH_OFF_GEN:    rd[7:0] = st_q.gen;
      MPH_OFF_STATUS: begin
        rd[MPH_ST_LAT_A] = lat_status(st_q.pa);
        rd[MPH_ST_AUX_A] = st_q.pa.aux_st;
        rd[MPH_ST_LAT_B] = lat_status(st_q.pb);
        rd[MPH_ST_AUX_B] = st_q.pb.aux_st;
      end
      MPH_OFF_DATA_A: rd[7:0] = (st_q.pa.ctrl[MPH_SUB_HI:MPH_SUB_LO] == MPH_SUB_IN)
                                ? st_q.pa.fl : st_q.pa.din_q;
      MPH_OFF_DATA_B: rd[7:0] = (st_q.pb.ctrl[MPH_SUB_HI:MPH_SUB_LO] == MPH_SUB_IN)
                                ? st_q.pb.fl : st_q.pb.din_q;
      MPH_OFF_DDR_A:  rd[7:0] = st_q.pa.ddr;
      MPH_OFF_DDR_B:  rd[7:0] = st_q.pb.ddr;
      default: ;
    endcase
    if (do_rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd;
      st_d.rerr   = !addr_known(s_axi_araddr);
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q         <= '0;
      st_q.pa.ctrl <= MPH_CTRL_RST;
      st_q.pb.ctrl <= MPH_CTRL_RST;
      st_q.gen     <= MPH_GEN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One write and one read outstanding; ready held low meanwhile
  assign s_axi_awready = !st_q.aw_hold && !st_q.bvalid;
  assign s_axi_wready  = !st_q.w_hold && !st_q.bvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.berr ? 2'h2 : 2'h0;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rerr ? 2'h2 : 2'h0;
  assign pin_a_out     = pin_drive(st_q.pa, st_q.gen[MPH_GEN_EN_A]);
  assign pin_b_out     = pin_drive(st_q.pb, st_q.gen[MPH_GEN_EN_B]);
  // Request gating by control bits 2 and 1
  assign req_a.aux_irq = st_q.pa.aux_st && st_q.pa.ctrl[MPH_AUX_IE];
  assign req_b.aux_irq = st_q.pb.aux_st && st_q.pb.ctrl[MPH_AUX_IE];
  assign req_a.service_request = lat_status(st_q.pa) && st_q.pa.ctrl[MPH_SVC_EN];
  assign req_b.service_request = lat_status(st_q.pb) && st_q.pb.ctrl[MPH_SVC_EN];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_hs_off_disabled: assert property (
    !st_q.gen[MPH_GEN_EN_A] |-> !pin_a_out.aux_out || !st_q.pa.ctrl[5] ||
      st_q.pa.ctrl[4:3] == 2'h1 || st_q.pa.ctrl[4:3] == 2'h0)
    else $error("handshake asserted while transfer disabled");
  a_hs_two_cyc: assert property (
    $rose(st_q.pa.pend) |-> !st_q.pa.hs ##1 !st_q.pa.hs ##1
      (st_q.pa.hs || !st_q.gen[MPH_GEN_EN_A] || !st_q.pa.pend))
    else $error("handshake not asserted two cycles after transfer");
  a_pulse_len: assert property (
    $rose(st_q.pb.hs) && st_q.pb.ctrl[5:3] == MPH_HS_PULSE |-> ##4 !st_q.pb.hs)
    else $error("pulse longer than four cycles");
  a_aux_clear: assert property (
    st_q.pa.ctrl[5] |=> !st_q.pa.aux_st)
    else $error("aux status set in output control");
  a_aux_edge: assert property (
    st_q.pa.sync_a[1] && !st_q.pa.a_prev && !st_q.pa.ctrl[5] &&
      st_q.gen[MPH_GEN_EN_A] && st_d.pa.ctrl == st_q.pa.ctrl |=> st_q.pa.aux_st)
    else $error("aux edge lost");
  a_fixed_out: assert property (
    st_q.pa.ctrl[5:3] == MPH_HS_ASRT |-> pin_a_out.aux_out && !pin_a_out.aux_oe_n)
    else $error("fixed asserted output wrong");
  a_aux_irq: assert property (
    req_a.aux_irq |-> st_q.pa.ctrl[MPH_AUX_IE] && st_q.pa.aux_st)
    else $error("aux interrupt not gated");
  a_empty_stat: assert property (
    st_q.pa.ctrl[7:6] == MPH_SUB_OUT && st_q.pa.ctrl[0] && st_q.pa.fl_full
      |-> !lat_status(st_q.pa))
    else $error("empty status wrong");
  a_data_stable: assert property (
    st_q.pa.hs && st_d.pa.hs |=> $stable(pin_a_out.data_out))
    else $error("data moved during handshake");

  c_pulse: cover property ($rose(st_q.pb.hs) && st_q.pb.ctrl[5:3] == MPH_HS_PULSE);
  c_ilock: cover property ($fell(st_q.pa.hs) && st_q.pa.ctrl[5:3] == MPH_HS_ILOCK);
  c_aux:   cover property ($rose(st_q.pb.aux_st));
  c_full:  cover property (st_q.pa.il_full && st_q.pa.fl_full);

endmodule
`default_nettype wire

// ### src/mph_pkg.sv
/*
  Package for the mode 0 port handshake controller: register offsets,
  control field positions, reset values, timing constants and carriers.
  Assumes a single 100 MHz system clock and an AXI4-Lite register bus.
*/
package mph_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MPH_OFF_A_CTRL = 8'h00;
  localparam logic [7:0] MPH_OFF_B_CTRL = 8'h04;
  localparam logic [7:0] MPH_OFF_GEN    = 8'h08;
  localparam logic [7:0] MPH_OFF_STATUS = 8'h0c;
  localparam logic [7:0] MPH_OFF_DATA_A = 8'h10;
  localparam logic [7:0] MPH_OFF_DATA_B = 8'h14;
  localparam logic [7:0] MPH_OFF_DDR_A  = 8'h18;
  localparam logic [7:0] MPH_OFF_DDR_B  = 8'h1c;

  // ----------------------------------------------------------------
  // Control field positions and encodings
  // ----------------------------------------------------------------
  localparam int MPH_SUB_HI   = 7;
  localparam int MPH_SUB_LO   = 6;
  localparam int MPH_HS_HI    = 5;
  localparam int MPH_HS_LO    = 3;
  localparam int MPH_AUX_IE   = 2;
  localparam int MPH_SVC_EN   = 1;
  localparam int MPH_STAT_SEL = 0;
  localparam logic [1:0] MPH_SUB_IN  = 2'h0;
  localparam logic [1:0] MPH_SUB_OUT = 2'h1;
  localparam logic [2:0] MPH_HS_NEG   = 3'h4;
  localparam logic [2:0] MPH_HS_ASRT  = 3'h5;
  localparam logic [2:0] MPH_HS_ILOCK = 3'h6;
  localparam logic [2:0] MPH_HS_PULSE = 3'h7;
  // General register bits: transfer enables
  localparam int MPH_GEN_EN_A = 4;
  localparam int MPH_GEN_EN_B = 5;
  // Status register bits per port: latch status, aux status
  localparam int MPH_ST_LAT_A = 0;
  localparam int MPH_ST_AUX_A = 1;
  localparam int MPH_ST_LAT_B = 2;
  localparam int MPH_ST_AUX_B = 3;

  localparam logic [7:0] MPH_CTRL_RST = 8'h00;
  localparam logic [7:0] MPH_GEN_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MPH_CLK_MHZ        = 100;
  localparam int MPH_ASSERT_DLY_CYC = 2;
  localparam int MPH_PULSE_CYC      = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       strobe_in;
    logic       aux_in;
  } mph_pin_in_t;

  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] data_oe_n;
    logic       aux_out;
    logic       aux_oe_n;
  } mph_pin_out_t;

  typedef struct packed {
    logic       service_request;
    logic       aux_irq;
  } mph_req_t;

endpackage

// ### test/mph_peer.sv
/*
  Peripheral model for one port: strobe input and aux status input.
  Assumes the block's clock; pins change just after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mph_peer
  import mph_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic       stb_kick,
  input  wire logic       aux_kick,
  input  wire logic       aux_out,
  output var mph_pin_in_t pin
);
  logic [2:0] ph_q  = 3'h0;
  logic [3:0] cnt_q = 4'h0;
  logic       aux_q = 1'h0;

  // Strobe high while the phase is 4 or 3, then low for two more
  assign pin = '{strobe_in: (ph_q >= 3'h3), aux_in: aux_q};

  // Answer a raised handshake after ack_dly cycles; a slow peer gives a long delay
  always @(posedge clk_sys) begin
    aux_q <= aux_kick;
    cnt_q <= (aux_out && ph_q == 3'h0) ? cnt_q + 4'h1 : 4'h0;
    if (ph_q != 3'h0)
      ph_q <= ph_q - 3'h1;
    else if (stb_kick || (ack_en && aux_out && cnt_q == ack_dly))
      ph_q <= 3'h4;
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
/*
  Self-checking bench for the mode 0 port handshake controller.
  Assumes an AXI4-Lite master here and one peer model on each port.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mph_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, design and peers
  // ----------------------------------------------------------------
  logic         clk_sys = 1'h0;
  logic         rstn    = 1'h0;
  logic [7:0]   awaddr  = 8'h00;
  logic [7:0]   araddr  = 8'h00;
  logic [31:0]  wdata   = 32'h0;
  logic         awvalid = 1'h0;
  logic         wvalid  = 1'h0;
  logic         arvalid = 1'h0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, r;
  logic [31:0]  rdata, v;
  logic [7:0]   da_in   = 8'h00;
  logic [1:0]   ack_en  = 2'h0;
  logic [1:0]   stb_k   = 2'h0;
  logic [1:0]   aux_k   = 2'h0;
  logic [3:0]   ack_dly = 4'h6;
  mph_pin_in_t  pa_in, pb_in;
  mph_pin_out_t pa_out, pb_out;
  mph_req_t     ra, rb;
  int           errors = 0;
  int           checks = 0;
  int           cycles = 0;
  int           n;

  mph_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'h1), .pin_a_in(pa_in), .pin_b_in(pb_in),
    .port_a_data_in(da_in), .port_b_data_in(8'h00), .pin_a_out(pa_out),
    .pin_b_out(pb_out), .req_a(ra), .req_b(rb));
  mph_peer peer_a (.clk_sys(clk_sys), .ack_en(ack_en[0]), .ack_dly(ack_dly),
    .stb_kick(stb_k[0]), .aux_kick(aux_k[0]), .aux_out(pa_out.aux_out), .pin(pa_in));
  mph_peer peer_b (.clk_sys(clk_sys), .ack_en(ack_en[1]), .ack_dly(ack_dly),
    .stb_kick(stb_k[1]), .aux_kick(aux_k[1]), .aux_out(pb_out.aux_out), .pin(pb_in));

  // Clock and a cycle ceiling well above the few hundred cycles used
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Both channels offered at once, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (pa || pw) begin
      @(posedge clk_sys);
      if (awready) pa = 1'h0;
      if (wready) pw = 1'h0;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge clk_sys); while (bvalid !== 1'h1);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk_sys); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk_sys); while (rvalid !== 1'h1);
    v = rdata;
    r = rresp;
  endtask
  function automatic logic aux_of(input int p);
    return p ? pb_out.aux_out : pa_out.aux_out;
  endfunction
  // Enable is dropped around each control write this task makes so the submode never moves live
  task automatic cfg(input int p, input logic [7:0] c, input logic en);
    wr(MPH_OFF_GEN, 32'h0);
    wr(MPH_OFF_A_CTRL + 8'(4 * p), {24'h0, c});
    wr(MPH_OFF_GEN, {26'h0, en & (p == 1), en & (p == 0), 4'h0});
  endtask
  task automatic kick_aux(input int p);
    aux_k[p] <= 1'h1;
    tick(3);
    aux_k[p] <= 1'h0;
    tick(4);
  endtask
  task automatic wait_aux(input int p, input logic lvl);
    n = 0;
    while (aux_of(p) !== lvl && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(MPH_OFF_A_CTRL);
    chk(v, 32'h0, "port a control reset");
    rd(MPH_OFF_B_CTRL);
    chk(v, 32'h0, "port b control reset");
    chk({pa_out.aux_oe_n, pa_out.data_oe_n}, 9'h1ff, "pins off at reset");
    rd(8'h20);
    chk(r, 2'h2, "unmapped read");
    wr(8'h0e, 32'hff);
    chk(bresp, 2'h2, "unaligned write refused");
    $display("test reset done");
  endtask
  task automatic t_static();
    for (int p = 0; p < 2; p++) begin
      for (int c = 4; c < 8; c++) begin
        cfg(p, {2'h1, 3'(c), 3'h0}, 1'h1);
        kick_aux(p);
        rd(MPH_OFF_STATUS);
        chk(v[2 * p + 1], 1'h0, "aux status clear");
        chk(aux_of(p), c == 5, "output pin level");
      end
    end
    $display("test static done");
  endtask
  task automatic t_aux();
    cfg(0, 8'h44, 1'h1);
    kick_aux(0);
    rd(MPH_OFF_STATUS);
    chk(v[1], 1'h1, "edge sets status");
    chk(ra.aux_irq, 1'h1, "aux irq enabled");
    wr(MPH_OFF_A_CTRL, 32'h40);
    chk(ra.aux_irq, 1'h0, "aux irq masked");
    wr(MPH_OFF_STATUS, 32'h2);
    rd(MPH_OFF_STATUS);
    chk(v[1], 1'h0, "write one clears");
    kick_aux(0);
    wr(MPH_OFF_GEN, 32'h0);
    rd(MPH_OFF_STATUS);
    chk(v[1], 1'h0, "enable clear clears");
    $display("test aux done");
  endtask
  task automatic t_ilock();
    wr(MPH_OFF_DDR_A, 32'hff);
    cfg(0, 8'h72, 1'h1);
    wr(MPH_OFF_DATA_A, 32'hc3);
    wait_aux(0, 1'h1);
    chk(n, MPH_ASSERT_DLY_CYC + 1, "assert delay");
    chk(pa_out.data_out, 8'hc3, "first data out");
    rd(MPH_OFF_STATUS);
    chk(v[0], 1'h1, "one latch free");
    chk(ra.service_request, 1'h1, "request enabled");
    wr(MPH_OFF_A_CTRL, 32'h73);
    rd(MPH_OFF_STATUS);
    chk(v[0], 1'h0, "not both empty");
    wr(MPH_OFF_A_CTRL, 32'h70);
    chk(ra.service_request, 1'h0, "request masked");
    wr(MPH_OFF_DATA_A, 32'h3c);
    rd(MPH_OFF_STATUS);
    chk(v[0], 1'h0, "both latches full");
    tick(10);
    chk({aux_of(0), pa_out.data_out}, 9'h1c3, "held until strobe");
    ack_dly <= 4'h2;
    ack_en[0] <= 1'h1;
    wait_aux(0, 1'h0);
    wait_aux(0, 1'h1);
    chk(pa_out.data_out, 8'h3c, "next data advanced");
    wait_aux(0, 1'h0);
    ack_en[0] <= 1'h0;
    wr(MPH_OFF_A_CTRL, 32'h73);
    rd(MPH_OFF_STATUS);
    chk(v[0], 1'h1, "both latches empty");
    stb_k[0] <= 1'h1;
    tick(1);
    stb_k[0] <= 1'h0;
    tick(8);
    chk({aux_of(0), pa_out.data_out}, 9'h03c, "strobe ignored");
    $display("test interlocked done");
  endtask
  task automatic t_pulse();
    wr(MPH_OFF_DDR_B, 32'hff);
    cfg(1, 8'h7a, 1'h1);
    wr(MPH_OFF_DATA_B, 32'h96);
    wait_aux(1, 1'h1);
    chk(pb_out.data_out, 8'h96, "port b data out");
    chk(rb.service_request, 1'h1, "port b request");
    wait_aux(1, 1'h0);
    chk(n, MPH_PULSE_CYC, "pulse length");
    // A strobe after the pulse finds the output negated and moves nothing
    wr(MPH_OFF_DATA_B, 32'h5a);
    stb_k[1] <= 1'h1;
    tick(1);
    stb_k[1] <= 1'h0;
    tick(8);
    rd(MPH_OFF_STATUS);
    chk(pb_out.data_out, 8'h96, "strobe after pulse ignored");
    chk(v[2], 1'h0, "queue kept full");
    cfg(1, 8'h70, 1'h0);
    wr(MPH_OFF_DATA_B, 32'h11);
    tick(12);
    chk(aux_of(1), 1'h0, "held off when disabled");
    $display("test pulsed done");
  endtask
  task automatic t_ddr_in();
    wr(MPH_OFF_DDR_A, 32'h0f);
    cfg(0, 8'h70, 1'h1);
    wr(MPH_OFF_DATA_A, 32'ha5);
    wait_aux(0, 1'h1);
    chk({pa_out.data_oe_n, pa_out.data_out}, 16'hf0a5, "input pins latch");
    wr(MPH_OFF_GEN, 32'h0);
    chk(aux_of(0), 1'h0, "handshake drops with enable");
    cfg(0, 8'h01, 1'h1);
    // The output word still sits in the final latch; one read drains it
    rd(MPH_OFF_DATA_A);
    da_in <= 8'h6e;
    stb_k[0] <= 1'h1;
    tick(1);
    stb_k[0] <= 1'h0;
    tick(8);
    rd(MPH_OFF_STATUS);
    chk(v[0], 1'h1, "unread input present");
    rd(MPH_OFF_DATA_A);
    chk(v, 32'h6e, "input data latched");
    rd(MPH_OFF_STATUS);
    chk(v[0], 1'h0, "input read out");
    $display("test direction and input done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    t_reset();
    t_static();
    t_aux();
    t_ilock();
    t_pulse();
    t_ddr_in();
    tally_and_finish();
  end
endmodule
`default_nettype wire
